// ===== hw/vpiu_regs.svh
// register indices, reset values, bit positions, vectors and modes of the interrupt unit
`ifndef VPIU_REGS_SVH
`define VPIU_REGS_SVH
`define VPIU_IDX_REQ_LO 2'h0
`define VPIU_IDX_REQ_HI 2'h1
`define VPIU_IDX_MASK_LO 2'h2
`define VPIU_IDX_MASK_HI 2'h3
`define VPIU_REQ_RESET 8'h00
`define VPIU_MASK_RESET 8'hFF
`define VPIU_LO_BITS 6
`define VPIU_HI_BITS 2
`define VPIU_BIT_WDT 0
`define VPIU_BIT_PIN_A 1
`define VPIU_BIT_PIN_B 2
`define VPIU_BIT_PIN_C 3
`define VPIU_BIT_SER_RX 4
`define VPIU_BIT_SER_TX 5
`define VPIU_BIT_TMR8 6
`define VPIU_BIT_TMR16 7
`define VPIU_VEC_NMI 16'h0004
`define VPIU_VEC_WDT 16'h0004
`define VPIU_VEC_PIN_A 16'h0006
`define VPIU_VEC_PIN_B 16'h0008
`define VPIU_VEC_PIN_C 16'h000A
`define VPIU_VEC_SER_RX 16'h000C
`define VPIU_VEC_SER_TX 16'h000E
`define VPIU_VEC_TMR8 16'h0014
`define VPIU_VEC_TMR16 16'h0016
`define VPIU_WDT_INTERVAL 2'h0
`define VPIU_WDT_MODE1 2'h1
`define VPIU_WDT_MODE2 2'h2
`endif

// ===== hw/vpiu_pkg.sv
// types shared by the interrupt unit
package vpiu_pkg;
  typedef struct packed {
    logic [15:0] vector;
    logic valid;
    logic nmi;
    logic [2:0] idx;
  } grant_t;
  typedef struct packed {
    logic we;
    logic re;
    logic [1:0] sel;
    logic [7:0] bit_en;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ===== hw/vectored_priority_interrupt_unit.sv
// vectored priority interrupt unit: request and mask flags, fixed-priority resolver, vector to core
// Operation
// - non-maskable request accepted despite global disable, above every maskable request
// - sole non-maskable source is watchdog overflow in mode 1, vector 0004H
// - every firing source raises a standby release pulse
// - three pin sources and five internal sources are maskable
// - simultaneous maskable requests are served lowest level first
// - pin edge requests take levels 1 to 3, vectors 0006H, 0008H, 000AH
// - serial receive and transfer share level 4 at 000CH; transmit level 5 at 000EH
// - byte timer level 6 at 0014H, wide timer level 7 at 0016H
// - request flag set by event or write, cleared by acknowledge, reset or write
// - request registers take bit or byte writes and reset to 00H
// - mask 0 permits, 1 blocks; masks reset to FFH
// - watchdog request flag writable only in interval mode; otherwise writes are ignored and the flag keeps its value
// - watchdog mask flag reads undefined in watchdog mode 1 or 2; here it reads 0 in any mode but interval mode
// - pin level changes set pin request flags; software masks before output use
// - maskable acknowledge needs request 1, mask 0, global enable 1; else pending
// - on acknowledge the core saves status and counter; global enable cleared
// - servicing starts nine to nineteen clocks after the request
// - acknowledge deferred while any flag register is accessed
`timescale 1ns/10ps
`include "vpiu_regs.svh"
module vectored_priority_interrupt_unit
  import vpiu_pkg::*;
#(
  parameter int NUM_SRC = 8
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_watchdog_overflow_req,
  input wire logic [1:0] i_wdt_mode,
  input wire logic i_pin_edge_req_a,
  input wire logic i_pin_edge_req_b,
  input wire logic i_pin_edge_req_c,
  input wire logic i_async_receive_done_req,
  input wire logic i_clocked_transfer_done_req,
  input wire logic i_async_transmit_done_req,
  input wire logic i_byte_timer_match_req,
  input wire logic i_wide_timer_match_req,
  input wire logic i_global_accept_flag,
  input wire logic i_ack,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  input wire logic [1:0] i_reg_sel,
  input wire logic [7:0] i_reg_bit_en,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic [15:0] o_vector,
  output logic o_vector_valid,
  output logic o_vector_nmi,
  output logic o_accept_clear,
  output logic o_standby_release
);

  reg_req_t bus;
  grant_t grant_reg;
  grant_t grant_next;
  logic [NUM_SRC-1:0] req_reg;
  logic [NUM_SRC-1:0] req_next;
  logic [NUM_SRC-1:0] mask_reg;
  logic [NUM_SRC-1:0] mask_next;
  logic [NUM_SRC-1:0] event_vec;
  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0] ack_clear;
  logic [NUM_SRC-1:0] wr_en;
  logic [NUM_SRC-1:0] wr_val;
  logic nmi_pend_reg;
  logic nmi_event;
  logic interval_mode;
  logic access;
  logic ack_ok;
  logic req_write;
  logic mask_write;
  logic sel_low;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic accept_clear_reg;
  logic standby_reg;

  assign bus = '{we: i_reg_we, re: i_reg_re, sel: i_reg_sel, bit_en: i_reg_bit_en, wdata: i_reg_wdata};
  assign interval_mode = (i_wdt_mode == `VPIU_WDT_INTERVAL);
  assign access = bus.we | bus.re;
  assign ack_ok = i_ack & grant_reg.valid;

  // watchdog overflow goes to at most one path by mode: request flag in interval mode, non-maskable in mode 1, neither otherwise
  assign nmi_event = i_watchdog_overflow_req & (i_wdt_mode == `VPIU_WDT_MODE1);

  // source events in priority order; pin inputs arrive already edge detected
  always_comb begin
    event_vec = '0;
    event_vec[`VPIU_BIT_WDT] = i_watchdog_overflow_req & interval_mode;
    event_vec[`VPIU_BIT_PIN_A] = i_pin_edge_req_a;
    event_vec[`VPIU_BIT_PIN_B] = i_pin_edge_req_b;
    event_vec[`VPIU_BIT_PIN_C] = i_pin_edge_req_c;
    event_vec[`VPIU_BIT_SER_RX] = i_async_receive_done_req | i_clocked_transfer_done_req;
    event_vec[`VPIU_BIT_SER_TX] = i_async_transmit_done_req;
    event_vec[`VPIU_BIT_TMR8] = i_byte_timer_match_req;
    event_vec[`VPIU_BIT_TMR16] = i_wide_timer_match_req;
  end

  // low registers hold six sources, high registers the two timers
  assign sel_low = (bus.sel == `VPIU_IDX_REQ_LO) || (bus.sel == `VPIU_IDX_MASK_LO);
  assign req_write = bus.we && ((bus.sel == `VPIU_IDX_REQ_LO) || (bus.sel == `VPIU_IDX_REQ_HI));
  assign mask_write = bus.we && ((bus.sel == `VPIU_IDX_MASK_LO) || (bus.sel == `VPIU_IDX_MASK_HI));

  always_comb begin
    if (sel_low) begin
      wr_en = {2'h0, bus.bit_en[`VPIU_LO_BITS-1:0]};
      wr_val = {2'h0, bus.wdata[`VPIU_LO_BITS-1:0]};
    end else begin
      wr_en = {bus.bit_en[`VPIU_HI_BITS-1:0], 6'h00};
      wr_val = {bus.wdata[`VPIU_HI_BITS-1:0], 6'h00};
    end
  end

  assign ack_clear = (ack_ok && !grant_reg.nmi) ? (NUM_SRC'(1) << grant_reg.idx) : '0;

  // per-source flag update; a source event wins over any clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_flag
      logic req_wr_ok;
      assign req_wr_ok = req_write && wr_en[gi] && ((gi != `VPIU_BIT_WDT) || interval_mode);
      always_comb begin
        if (event_vec[gi]) begin
          req_next[gi] = 1'b1;
        end else if (req_wr_ok) begin
          req_next[gi] = wr_val[gi];
        end else if (ack_clear[gi]) begin
          req_next[gi] = 1'b0;
        end else begin
          req_next[gi] = req_reg[gi];
        end
        mask_next[gi] = (mask_write && wr_en[gi]) ? wr_val[gi] : mask_reg[gi];
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      req_reg <= `VPIU_REQ_RESET;
      mask_reg <= `VPIU_MASK_RESET;
    end else begin
      req_reg <= req_next;
      mask_reg <= mask_next;
    end
  end

  // non-maskable pending; a new overflow during acknowledge is kept
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      nmi_pend_reg <= 1'b0;
    end else if (nmi_event) begin
      nmi_pend_reg <= 1'b1;
    end else if (ack_ok && grant_reg.nmi) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  function automatic logic [15:0] vector_of(input logic [2:0] idx);
    case (idx)
      3'h0: vector_of = `VPIU_VEC_WDT;
      3'h1: vector_of = `VPIU_VEC_PIN_A;
      3'h2: vector_of = `VPIU_VEC_PIN_B;
      3'h3: vector_of = `VPIU_VEC_PIN_C;
      3'h4: vector_of = `VPIU_VEC_SER_RX;
      3'h5: vector_of = `VPIU_VEC_SER_TX;
      3'h6: vector_of = `VPIU_VEC_TMR8;
      3'h7: vector_of = `VPIU_VEC_TMR16;
      default: vector_of = `VPIU_VEC_WDT;
    endcase
  endfunction

  assign eligible = req_reg & ~mask_reg & {NUM_SRC{i_global_accept_flag}};

  // resolver; valid drops on the acknowledge cycle so a stale grant is never taken twice
  always_comb begin
    grant_next = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        grant_next.idx = 3'(i);
      end
    end
    grant_next.vector = vector_of(grant_next.idx);
    grant_next.valid = |eligible;
    if (nmi_pend_reg) begin
      grant_next.nmi = 1'b1;
      grant_next.valid = 1'b1;
      grant_next.vector = `VPIU_VEC_NMI;
      grant_next.idx = 3'h0;
    end
    // flag register traffic holds every grant back, the non-maskable one too
    if (access || ack_ok) begin
      grant_next.valid = 1'b0;
    end
  end

  // one clock from flag to grant keeps the core inside its nine clock minimum
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      grant_reg <= '0;
    end else begin
      grant_reg <= grant_next;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      accept_clear_reg <= 1'b0;
      standby_reg <= 1'b0;
    end else begin
      accept_clear_reg <= ack_ok;
      standby_reg <= nmi_event | (|event_vec);
    end
  end

  // read data; watchdog mask bit reads 0 outside interval mode
  always_comb begin
    case (bus.sel)
      `VPIU_IDX_REQ_LO: rdata_next = {2'h0, req_reg[`VPIU_LO_BITS-1:0]};
      `VPIU_IDX_REQ_HI: rdata_next = {6'h00, req_reg[NUM_SRC-1:`VPIU_LO_BITS]};
      `VPIU_IDX_MASK_LO: rdata_next = {2'h3, mask_reg[`VPIU_LO_BITS-1:1], mask_reg[0] & interval_mode};
      `VPIU_IDX_MASK_HI: rdata_next = {6'h3F, mask_reg[NUM_SRC-1:`VPIU_LO_BITS]};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= 8'h00;
    end else if (bus.re) begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_vector = grant_reg.vector;
  assign o_vector_valid = grant_reg.valid;
  assign o_vector_nmi = grant_reg.nmi;
  assign o_accept_clear = accept_clear_reg;
  assign o_standby_release = standby_reg;

  logic [NUM_SRC-1:0] elig_past;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      elig_past <= '0;
    end else begin
      elig_past <= eligible;
    end
  end

  a_nmi_overrides: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (nmi_pend_reg && !access && !ack_ok) |=> (grant_reg.valid && grant_reg.nmi))
    else $error("pending non-maskable request not granted");

  a_nmi_vector: assert property (@(posedge i_clock) disable iff (!i_nrst)
    grant_reg.nmi |-> (grant_reg.vector == `VPIU_VEC_NMI))
    else $error("non-maskable grant carries wrong vector");

  a_nmi_cause: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $rose(nmi_pend_reg) |-> $past(i_watchdog_overflow_req && (i_wdt_mode == `VPIU_WDT_MODE1)))
    else $error("non-maskable pending without mode 1 overflow");

  a_standby_pulse: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (nmi_event || (|event_vec)) |=> o_standby_release)
    else $error("source fired without standby release");

  a_priority_low: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (grant_reg.valid && !grant_reg.nmi) |-> ((elig_past & ((8'h01 << grant_reg.idx) - 8'h01)) == 8'h00))
    else $error("lower level request skipped");

  a_vector_map: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (grant_reg.valid && !grant_reg.nmi) |-> (grant_reg.vector == vector_of(grant_reg.idx)))
    else $error("maskable grant vector mismatch");

  a_grant_allowed: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (grant_reg.valid && !grant_reg.nmi) |-> elig_past[grant_reg.idx])
    else $error("grant for masked, absent or disabled request");

  a_access_defers: assert property (@(posedge i_clock) disable iff (!i_nrst)
    access |=> !grant_reg.valid)
    else $error("grant issued during flag register access");

  a_event_sets: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (|event_vec) |=> (($past(event_vec) & ~req_reg) == 8'h00))
    else $error("source event did not set its flag");

  a_ack_clears: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (ack_ok && !grant_reg.nmi && !event_vec[grant_reg.idx] && !req_write)
      |=> (!req_reg[$past(grant_reg.idx)] && o_accept_clear))
    else $error("acknowledge did not clear flag or global enable");

  a_grant_latency: assert property (@(posedge i_clock) disable iff (!i_nrst)
    ((|eligible) && !access && !ack_ok) |=> grant_reg.valid)
    else $error("eligible request not granted on the next clock");

  a_accept_pulse: assert property (@(posedge i_clock) disable iff (!i_nrst)
    ack_ok |=> (o_accept_clear && !o_vector_valid))
    else $error("acknowledge not followed by enable clear");

  a_valid_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (grant_reg.valid && !grant_reg.nmi) |-> $past(i_global_accept_flag))
    else $error("maskable grant while global enable low");

  a_wdt_guard: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (req_write && !interval_mode && !ack_clear[`VPIU_BIT_WDT])
      |=> (req_reg[`VPIU_BIT_WDT] == $past(req_reg[`VPIU_BIT_WDT])))
    else $error("watchdog request flag written outside interval mode");

  a_mask_undef: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (bus.re && (bus.sel == `VPIU_IDX_MASK_LO) && !interval_mode) |=> !o_reg_rdata[`VPIU_BIT_WDT])
    else $error("watchdog mask bit read back outside interval mode");

  a_pin_flags: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_pin_edge_req_a || i_pin_edge_req_b || i_pin_edge_req_c)
      |=> ((req_reg[`VPIU_BIT_PIN_A] || !$past(i_pin_edge_req_a))
        && (req_reg[`VPIU_BIT_PIN_B] || !$past(i_pin_edge_req_b))
        && (req_reg[`VPIU_BIT_PIN_C] || !$past(i_pin_edge_req_c))))
    else $error("pin edge did not set its request flag");

  a_shared_flag: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_async_receive_done_req || i_clocked_transfer_done_req) |=> req_reg[`VPIU_BIT_SER_RX])
    else $error("serial receive or transfer end did not set the shared flag");

  a_timer_flags: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_byte_timer_match_req || i_wide_timer_match_req)
      |=> ((req_reg[`VPIU_BIT_TMR8] || !$past(i_byte_timer_match_req))
        && (req_reg[`VPIU_BIT_TMR16] || !$past(i_wide_timer_match_req))))
    else $error("timer match did not set its request flag");

  c_nmi_grant: cover property (@(posedge i_clock) disable iff (!i_nrst)
    grant_reg.valid && grant_reg.nmi && i_ack);
  c_two_pending: cover property (@(posedge i_clock) disable iff (!i_nrst)
    ($countones(eligible) > 1) ##1 grant_reg.valid);
  c_ack_maskable: cover property (@(posedge i_clock) disable iff (!i_nrst)
    ack_ok && !grant_reg.nmi ##1 o_accept_clear);
  c_access_defer: cover property (@(posedge i_clock) disable iff (!i_nrst)
    (access && (|(req_reg & ~mask_reg))) ##1 !grant_reg.valid);
  c_nmi_disabled: cover property (@(posedge i_clock) disable iff (!i_nrst)
    (nmi_pend_reg && !i_global_accept_flag) ##1 (grant_reg.valid && grant_reg.nmi));

endmodule

// ===== bench/core_model.sv
// core sequencer model: takes grants and drives the global enable
`timescale 1ns/10ps
module core_model (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire logic i_nmi,
  input wire logic i_accept_clear,
  input wire logic i_allow,
  input wire logic i_slow,
  output logic o_ack,
  output logic o_accept
);
  logic [3:0] wait_reg;
  always @(negedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack <= 1'b0;
      o_accept <= 1'b0;
      wait_reg <= 4'h0;
    end else begin
      // non-maskable grant is taken even with the enable low
      o_ack <= !o_ack && i_valid && (o_accept || i_nmi);
      if (i_accept_clear) begin
        o_accept <= 1'b0;
        wait_reg <= i_slow ? 4'h7 : 4'h0;
      end else if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else begin
        o_accept <= i_allow;
      end
    end
  end
endmodule

// ===== bench/test_vectored_priority_interrupt_unit.sv
// self-checking bench for the vectored priority interrupt unit
`timescale 1ns/10ps
module test_vectored_priority_interrupt_unit;
  import vpiu_pkg::*;
  localparam logic [15:0] VTAB [8] = '{16'h0004, 16'h0006, 16'h0008, 16'h000A,
                                      16'h000C, 16'h000E, 16'h0014, 16'h0016};
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [8:0] ev;
  logic [1:0] mode;
  logic ack, ie, valid, nmi, aclr, stby, allow, slow;
  logic rd_q = 1'b0;
  logic ev_q = 1'b0;
  logic ack_q = 1'b0;
  logic acc_q = 1'b0;
  logic [7:0] rdata;
  logic [15:0] vec;
  reg_req_t rq;
  logic [15:0] exp_vec [$];
  logic [7:0] exp_rd [$];
  int num_errors = 0;
  int total_checks = 0;
  logic [8:0] s;

  always #20 i_clock = ~i_clock;

  vectored_priority_interrupt_unit vectored_priority_interrupt_unit_i (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_watchdog_overflow_req(ev[0]), .i_wdt_mode(mode),
    .i_pin_edge_req_a(ev[1]), .i_pin_edge_req_b(ev[2]), .i_pin_edge_req_c(ev[3]),
    .i_async_receive_done_req(ev[4]), .i_clocked_transfer_done_req(ev[8]),
    .i_async_transmit_done_req(ev[5]), .i_byte_timer_match_req(ev[6]), .i_wide_timer_match_req(ev[7]),
    .i_global_accept_flag(ie), .i_ack(ack), .i_reg_we(rq.we), .i_reg_re(rq.re), .i_reg_sel(rq.sel),
    .i_reg_bit_en(rq.bit_en), .i_reg_wdata(rq.wdata), .o_reg_rdata(rdata), .o_vector(vec),
    .o_vector_valid(valid), .o_vector_nmi(nmi), .o_accept_clear(aclr), .o_standby_release(stby));

  core_model core_model_i (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_valid(valid), .i_nmi(nmi), .i_accept_clear(aclr),
    .i_allow(allow), .i_slow(slow), .o_ack(ack), .o_accept(ie));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [1:0] sel, input logic [7:0] en, input logic [7:0] d);
    @(negedge i_clock);
    rq = '{we: 1'b1, re: 1'b0, sel: sel, bit_en: en, wdata: d};
    @(negedge i_clock);
    rq.we = 1'b0;
  endtask

  task automatic rd(input logic [1:0] sel, input logic [7:0] e);
    @(negedge i_clock);
    rq = '{we: 1'b0, re: 1'b1, sel: sel, bit_en: 8'h00, wdata: 8'h00};
    exp_rd.push_back(e);
    @(negedge i_clock);
    rq.re = 1'b0;
  endtask

  task automatic pulse(input logic [8:0] src);
    @(negedge i_clock);
    ev = src;
    @(negedge i_clock);
    ev = 9'h000;
  endtask

  // receive and transfer share one flag, so bit 8 folds into bit 4
  task automatic push_vecs(input logic [8:0] src);
    for (int i = 0; i < 8; i++)
      if (src[i] || (i == 4 && src[8]))
        exp_vec.push_back(VTAB[i]);
  endtask

  // bounded wait for every noted result, then let the clear pulse pass
  task automatic drain;
    int n;
    for (n = 0; n < 300 && (exp_vec.size() > 0 || exp_rd.size() > 0); n++)
      @(negedge i_clock);
    if (n == 300) begin
      num_errors++;
      complete_run();
    end else begin
      repeat (3) @(negedge i_clock);
    end
  endtask

  // an ack with nothing noted meets an unknown expectation and fails
  always @(posedge i_clock) begin
    if (i_nrst && ack && valid) begin
      check(vec, exp_vec.size() > 0 ? exp_vec.pop_front() : 16'hXXXX);
      check({15'h0000, nmi}, {15'h0000, (mode == 2'h1)});
    end
    if (rd_q)
      check({8'h00, rdata}, exp_rd.size() > 0 ? exp_rd.pop_front() : 8'hXX);
    rd_q <= rq.re;
    ev_q <= |ev;
    ack_q <= i_nrst && ack && valid;
    acc_q <= rq.we || rq.re;
  end

  // enable clear follows a taken ack by one clock; ack and flag traffic both hold the grant back
  always @(negedge i_clock)
    if (i_nrst) begin
      check({15'h0000, stby}, {15'h0000, ev_q});
      check({15'h0000, aclr}, {15'h0000, ack_q});
      if (ack_q || acc_q)
        check({15'h0000, valid}, 16'h0000);
    end

  initial begin
    void'($urandom(855));
    ev = 9'h000;
    mode = 2'h0;
    rq = '0;
    allow = 1'b0;
    slow = 1'b0;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    i_nrst = 1'b1;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'hFF);
    rd(2'h3, 8'hFF);
    wr(2'h2, 8'hFF, 8'hC0);
    wr(2'h3, 8'hFF, 8'hFC);
    rd(2'h2, 8'hC0);
    rd(2'h3, 8'hFC);
    allow = 1'b1;
    for (int k = 0; k < 8; k++) begin
      s = (k == 0) ? 9'h110 : 9'($urandom);
      if (s == 9'h000)
        s = 9'h0FF;
      slow = 1'($urandom);
      push_vecs(s);
      pulse(s);
      drain();
    end
    wr(2'h2, 8'h02, 8'h02);
    pulse(9'h002);
    repeat (4) @(negedge i_clock);
    rd(2'h0, 8'h02);
    exp_vec.push_back(16'h0006);
    wr(2'h2, 8'h02, 8'h00);
    drain();
    allow = 1'b0;
    repeat (3) @(negedge i_clock);
    pulse(9'h040);
    mode = 2'h1;
    exp_vec.push_back(16'h0004);
    pulse(9'h001);
    drain();
    rd(2'h1, 8'h01);
    wr(2'h0, 8'h01, 8'h01);
    rd(2'h0, 8'h00);
    wr(2'h2, 8'h01, 8'h01);
    rd(2'h2, 8'hC0);
    mode = 2'h0;
    wr(2'h2, 8'h01, 8'h00);
    exp_vec.push_back(16'h0014);
    allow = 1'b1;
    drain();
    exp_vec.push_back(16'h0016);
    wr(2'h1, 8'hFF, 8'h02);
    drain();
    wr(2'h2, 8'h08, 8'h08);
    pulse(9'h008);
    wr(2'h0, 8'h08, 8'h00);
    rd(2'h0, 8'h00);
    wr(2'h2, 8'h08, 8'h00);
    drain();
    complete_run();
  end
endmodule
